// [logic/hlb_cfg.svh]
// command codes, field positions and reset values of the list buffer port
`ifndef HLB_CFG_SVH
`define HLB_CFG_SVH
`define XCNT_RD     8'h22
`define XCNT_WR     8'hA2
`define INT_RD      8'h24
`define INT_WR      8'hA4
`define ISOLEN_RD   8'h2A
`define ISOLEN_WR   8'hAA
`define ATLLEN_RD   8'h2B
`define ATLLEN_WR   8'hAB
`define STAT_RD     8'h2C
`define RBL0_RD     8'h2D
`define RBL1_RD     8'h2E
`define ISO_RD      8'h40
`define ISO_WR      8'hC0
`define ATL_RD      8'h41
`define ATL_WR      8'hC1
`define WORD_STEP   16'h0002
`define RAM_BYTES   4096
`define RAM_AW      12
`define EOT_BIT     2
`define DONE_LSB    3
`define FULL_LSB    0
`define BUF_ATL     2
`define RST16       16'h0000
`define RST8        8'h00
`endif

// [logic/hlb_pkg.sv]
// types shared by the list buffer port logic
package hlb_pkg;
  typedef enum {
    M_IDLE,
    M_ISO_RD,
    M_ISO_WR,
    M_ATL_RD,
    M_ATL_WR,
    M_REG_RD,
    M_REG_WR
  } mode_t;
endpackage

// [logic/buf_pointer.sv]
// auto-incrementing word pointer bounded by the transfer byte count
`timescale 1ns/1ps
`include "hlb_cfg.svh"
module buf_pointer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // control
  input  wire logic         start_in,
  input  wire logic         step_in,
  input  wire logic [W-1:0] count_in,
  // state
  output logic      [W-1:0] off_out,
  output logic              act_out,
  output logic              eot_out
);
  logic [W-1:0] off_ff;
  logic [W-1:0] nxt_off;
  logic [W-1:0] sum;
  logic         act_ff;
  logic         nxt_act;

  assign sum     = off_ff + W'(`WORD_STEP);
  assign off_out = off_ff;
  assign act_out = act_ff;

  always_comb begin
    nxt_off = off_ff;
    nxt_act = act_ff;
    eot_out = 1'b0;
    if (start_in) begin
      nxt_off = '0;
      nxt_act = (count_in != '0);
    end else if (step_in && act_ff) begin
      nxt_off = sum;
      if (sum >= count_in) begin
        nxt_act = 1'b0;
        eot_out = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      off_ff <= '0;
      act_ff <= 1'b0;
    end else begin
      off_ff <= nxt_off;
      act_ff <= nxt_act;
    end
  end
endmodule // buf_pointer

// [logic/host_list_buffer_ram_port.sv]
// processor access to the host controller list buffer ram
`timescale 1ns/1ps
`include "hlb_cfg.svh"
module host_list_buffer_ram_port
  import hlb_pkg::*;
#(
  parameter int RAM_BYTES = `RAM_BYTES
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // processor command/data bus
  input  wire logic        cmd_wr_in,
  input  wire logic        data_wr_in,
  input  wire logic        data_rd_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  // controller side
  input  wire logic        hc_wr_in,
  input  wire logic        hc_rd_in,
  input  wire logic [11:0] hc_addr_in,
  input  wire logic [7:0]  hc_wdata_in,
  output logic      [7:0]  hc_rdata_out,
  input  wire logic        hc_deposit_in,
  input  wire logic        hc_deposit_buf_in,
  input  wire logic [15:0] hc_deposit_len_in,
  input  wire logic [2:0]  hc_done_in,
  // status
  output logic             all_eot_out,
  output logic      [5:0]  buf_status_out
);
  logic [7:0]  ram_ff [RAM_BYTES];
  mode_t       mode_ff, nxt_mode;
  logic [7:0]  code_ff, nxt_code;
  logic [15:0] xcnt_ff, nxt_xcnt;
  logic [15:0] isolen_ff, nxt_isolen;
  logic [15:0] atllen_ff, nxt_atllen;
  logic [15:0] rbl0_ff, nxt_rbl0;
  logic [15:0] rbl1_ff, nxt_rbl1;
  logic [2:0]  full_ff, nxt_full;
  logic [2:0]  done_ff, nxt_done;
  logic        eot_ff, nxt_eot;
  logic        iso_sel_ff, nxt_iso_sel;
  logic [15:0] dout_ff, nxt_dout;
  logic [7:0]  hrd_ff, nxt_hrd;
  logic [7:0]  cmd;
  logic        iso_start, atl_start, iso_step, atl_step;
  logic [15:0] iso_off, atl_off;
  logic        iso_act, atl_act, iso_eot, atl_eot;
  logic [11:0] iso_base, iso_a, iso_a1, atl_a, atl_a1;
  logic        port_wr_iso, port_wr_atl;

  assign cmd       = data_in[7:0];
  assign iso_start = cmd_wr_in && (cmd == `ISO_RD || cmd == `ISO_WR);
  assign atl_start = cmd_wr_in && (cmd == `ATL_RD || cmd == `ATL_WR);
  assign iso_step  = (data_rd_in && mode_ff == M_ISO_RD)
                  || (data_wr_in && mode_ff == M_ISO_WR);
  assign atl_step  = (data_rd_in && mode_ff == M_ATL_RD)
                  || (data_wr_in && mode_ff == M_ATL_WR);
  assign port_wr_iso = data_wr_in && mode_ff == M_ISO_WR && iso_act;
  assign port_wr_atl = data_wr_in && mode_ff == M_ATL_WR && atl_act;

  // buffer layout: iso0, iso1 of equal length, then acked buffer
  assign iso_base = iso_sel_ff ? isolen_ff[11:0] : 12'h000;
  assign iso_a    = iso_base + iso_off[11:0];
  assign iso_a1   = iso_a + 12'h001;
  assign atl_a    = isolen_ff[10:0] * 12'h002 + atl_off[11:0];
  assign atl_a1   = atl_a + 12'h001;

  buf_pointer #(.W(16)) u_iso_ptr (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (iso_start),
    .step_in  (iso_step),
    .count_in (xcnt_ff),
    .off_out  (iso_off),
    .act_out  (iso_act),
    .eot_out  (iso_eot)
  );

  buf_pointer #(.W(16)) u_atl_ptr (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (atl_start),
    .step_in  (atl_step),
    .count_in (xcnt_ff),
    .off_out  (atl_off),
    .act_out  (atl_act),
    .eot_out  (atl_eot)
  );

  // byte storage; the processor port wins a same-cycle controller write
  always_ff @(posedge clk_in) begin
    if (port_wr_iso) begin
      ram_ff[iso_a]  <= data_in[15:8];
      ram_ff[iso_a1] <= data_in[7:0];
    end else if (port_wr_atl) begin
      ram_ff[atl_a1] <= data_in[15:8];
      ram_ff[atl_a]  <= data_in[7:0];
    end else if (hc_wr_in) begin
      ram_ff[hc_addr_in] <= hc_wdata_in;
    end
  end

  always_comb begin
    nxt_mode    = mode_ff;
    nxt_code    = code_ff;
    nxt_xcnt    = xcnt_ff;
    nxt_isolen  = isolen_ff;
    nxt_atllen  = atllen_ff;
    nxt_rbl0    = rbl0_ff;
    nxt_rbl1    = rbl1_ff;
    nxt_full    = full_ff;
    nxt_done    = done_ff;
    nxt_eot     = eot_ff;
    nxt_iso_sel = iso_sel_ff;
    nxt_dout    = dout_ff;
    nxt_hrd     = hc_rd_in ? ram_ff[hc_addr_in] : hrd_ff;
    if (cmd_wr_in) begin
      nxt_code = cmd;
      case (cmd)
        `ISO_RD: nxt_mode = M_ISO_RD;
        `ISO_WR: nxt_mode = M_ISO_WR;
        `ATL_RD: nxt_mode = M_ATL_RD;
        `ATL_WR: nxt_mode = M_ATL_WR;
        default: nxt_mode = cmd[7] ? M_REG_WR : M_REG_RD;
      endcase
    end
    if (data_rd_in) begin
      case (mode_ff)
        M_ISO_RD: nxt_dout = {ram_ff[iso_a], ram_ff[iso_a1]};
        M_ATL_RD: nxt_dout = {ram_ff[atl_a1], ram_ff[atl_a]};
        M_REG_RD: begin
          case (code_ff)
            `RBL0_RD:   nxt_dout = rbl0_ff;
            `RBL1_RD:   nxt_dout = rbl1_ff;
            `STAT_RD:   nxt_dout = {10'h000, done_ff, full_ff};
            `XCNT_RD:   nxt_dout = xcnt_ff;
            `ISOLEN_RD: nxt_dout = isolen_ff;
            `ATLLEN_RD: nxt_dout = atllen_ff;
            `INT_RD:    nxt_dout = {13'h0000, eot_ff, 2'h0};
            default:    nxt_dout = `RST16;
          endcase
        end
        default: nxt_dout = dout_ff;
      endcase
    end
    if (data_wr_in && mode_ff == M_REG_WR) begin
      case (code_ff)
        `XCNT_WR:   nxt_xcnt   = data_in;
        `ISOLEN_WR: nxt_isolen = data_in;
        `ATLLEN_WR: nxt_atllen = data_in;
        `INT_WR:    nxt_eot    = eot_ff & ~data_in[`EOT_BIT];
        default:    nxt_eot    = eot_ff;
      endcase
    end
    // end of transfer and controller side events; sets below override the clears above
    if (iso_eot) begin
      nxt_eot = 1'b1;
      nxt_full[iso_sel_ff] = (mode_ff == M_ISO_WR);
      nxt_done[iso_sel_ff] = 1'b0;
      nxt_iso_sel = ~iso_sel_ff;
    end
    if (atl_eot) begin
      nxt_eot = 1'b1;
      nxt_full[`BUF_ATL] = (mode_ff == M_ATL_WR);
      nxt_done[`BUF_ATL] = 1'b0;
    end
    // a deposit sets full even when a read burst ends in the same cycle
    if (hc_deposit_in) begin
      if (hc_deposit_buf_in) begin
        nxt_rbl1    = hc_deposit_len_in;
        nxt_full[1] = 1'b1;
      end else begin
        nxt_rbl0    = hc_deposit_len_in;
        nxt_full[0] = 1'b1;
      end
    end
    nxt_done = nxt_done | hc_done_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff    <= M_IDLE;
      code_ff    <= `RST8;
      xcnt_ff    <= `RST16;
      isolen_ff  <= `RST16;
      atllen_ff  <= `RST16;
      rbl0_ff    <= `RST16;
      rbl1_ff    <= `RST16;
      full_ff    <= 3'h0;
      done_ff    <= 3'h0;
      eot_ff     <= 1'b0;
      iso_sel_ff <= 1'b0;
      dout_ff    <= `RST16;
      hrd_ff     <= `RST8;
    end else begin
      mode_ff    <= nxt_mode;
      code_ff    <= nxt_code;
      xcnt_ff    <= nxt_xcnt;
      isolen_ff  <= nxt_isolen;
      atllen_ff  <= nxt_atllen;
      rbl0_ff    <= nxt_rbl0;
      rbl1_ff    <= nxt_rbl1;
      full_ff    <= nxt_full;
      done_ff    <= nxt_done;
      eot_ff     <= nxt_eot;
      iso_sel_ff <= nxt_iso_sel;
      dout_ff    <= nxt_dout;
      hrd_ff     <= nxt_hrd;
    end
  end

  assign data_out       = dout_ff;
  assign hc_rdata_out   = hrd_ff;
  assign all_eot_out    = eot_ff;
  assign buf_status_out = {done_ff, full_ff};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_rbl0_read: assert property (
    data_rd_in && mode_ff == M_REG_RD && code_ff == `RBL0_RD
    |=> data_out == $past(rbl0_ff))
    else $error("iso buffer 0 length read wrong");
  a_rbl1_read: assert property (
    data_rd_in && mode_ff == M_REG_RD && code_ff == `RBL1_RD
    |=> data_out == $past(rbl1_ff))
    else $error("iso buffer 1 length read wrong");
  a_iso_order: assert property (
    data_rd_in && mode_ff == M_ISO_RD && !port_wr_atl
    |=> data_out[15:8] == $past(ram_ff[iso_a]) && data_out[7:0] == $past(ram_ff[iso_a1]))
    else $error("iso port byte order wrong");
  a_atl_order: assert property (
    data_rd_in && mode_ff == M_ATL_RD
    |=> data_out[7:0] == $past(ram_ff[atl_a]) && data_out[15:8] == $past(ram_ff[atl_a1]))
    else $error("acked port byte order wrong");
  a_iso_select: assert property (
    cmd_wr_in && cmd == `ISO_WR ##1 data_wr_in && !cmd_wr_in |=> mode_ff == M_ISO_WR)
    else $error("iso write code not selecting port");
  a_atl_select: assert property (
    cmd_wr_in && cmd == `ATL_RD |=> mode_ff == M_ATL_RD && atl_off == 16'h0000)
    else $error("acked read code not selecting port");
  a_ptr_step: assert property (
    iso_step && iso_act && !iso_eot && !cmd_wr_in
    |=> iso_off == $past(iso_off) + 16'h0002 && iso_act)
    else $error("iso pointer did not advance two bytes");
  a_eot_flag: assert property (
    (iso_eot || atl_eot) |=> all_eot_out ##1 !$rose(all_eot_out))
    else $error("end of transfer did not set flag");
  a_no_early_eot: assert property (
    $rose(all_eot_out) |-> $past(iso_eot || atl_eot))
    else $error("flag set without end of transfer");
  a_atl_full: assert property (
    atl_eot && mode_ff == M_ATL_WR && !hc_done_in[`BUF_ATL]
    |=> buf_status_out[`BUF_ATL] && !buf_status_out[5])
    else $error("acked full flag not set");
  a_ptr_restart: assert property (
    iso_start && xcnt_ff != 16'h0000 |=> iso_off == 16'h0000 && iso_act)
    else $error("iso pointer not reset by command");
  a_deposit_len: assert property (
    hc_deposit_in && !hc_deposit_buf_in |=> rbl0_ff == $past(hc_deposit_len_in) && buf_status_out[0])
    else $error("read-back length not updated");

  c_iso_burst: cover property (iso_start ##[1:20] iso_eot);
  c_atl_burst: cover property (atl_start ##[1:20] atl_eot);
  c_eot_clear: cover property (all_eot_out ##[1:10] !all_eot_out);
endmodule // host_list_buffer_ram_port

// [testbench/cpu_bus_model.sv]
// processor model on the command/data bus of the list buffer port
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input  wire logic        clk_in,
  // bus
  input  wire logic [15:0] rdata_in,
  output logic             cmd_wr_out,
  output logic             data_wr_out,
  output logic             data_rd_out,
  output logic      [15:0] wdata_out
);
  logic [15:0] wbuf [8];
  logic [15:0] rbuf [8];
  initial begin
    cmd_wr_out  = 1'b0;
    data_wr_out = 1'b0;
    data_rd_out = 1'b0;
    wdata_out   = 16'h0000;
  end
  // code once, then whole words; the code stays on the bus until the next word
  task automatic cmd(input logic [7:0] code);
    @(negedge clk_in);
    cmd_wr_out = 1'b1;
    wdata_out  = {8'h00, code};
    @(negedge clk_in);
    cmd_wr_out = 1'b0;
  endtask
  task automatic wreg(input logic [7:0] code, input logic [15:0] v);
    cmd(code);
    data_wr_out = 1'b1;
    wdata_out   = v;
    @(negedge clk_in);
    data_wr_out = 1'b0;
    wdata_out   = ~v;
  endtask
  // strobe held high across a burst of 16-bit words
  task automatic wr_n(input int n);
    for (int i = 0; i < n; i++) begin
      data_wr_out = 1'b1;
      wdata_out   = wbuf[i];
      @(negedge clk_in);
    end
    data_wr_out = 1'b0;
    wdata_out   = ~wdata_out;
  endtask
  // reads release the data bus, which then shows the inverse
  task automatic rd_n(input int s, input int n);
    data_rd_out = 1'b1;
    wdata_out   = ~wdata_out;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      rbuf[s+i] = rdata_in;
    end
    data_rd_out = 1'b0;
  endtask
endmodule // cpu_bus_model

// [testbench/testbench.sv]
// self-checking bench for the list buffer ram port
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] ISO_LEN = 16'h0100;
  localparam logic [15:0] ACK_LEN = 16'h0200;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cmd_wr, data_wr, data_rd, all_eot;
  logic [15:0] wdata, rdata;
  logic        hc_wr;
  logic        hc_rd;
  logic        dep;
  logic        dep_buf;
  logic [11:0] hc_addr;
  logic [7:0]  hc_wdata;
  logic [7:0]  hc_rdata;
  logic [7:0]  mem [8];
  logic [15:0] dep_len;
  logic [2:0]  hc_done;
  logic [5:0]  status;
  int          n_errors = 0;
  int          total_checks = 0;
  int          seed = 14;
  int          n;
  always #4 clk_in = ~clk_in;
  cpu_bus_model i_cpu (.clk_in(clk_in), .rdata_in(rdata), .cmd_wr_out(cmd_wr),
    .data_wr_out(data_wr), .data_rd_out(data_rd), .wdata_out(wdata));
  host_list_buffer_ram_port #(.RAM_BYTES(4096)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .cmd_wr_in(cmd_wr), .data_wr_in(data_wr), .data_rd_in(data_rd), .data_in(wdata),
    .data_out(rdata), .hc_wr_in(hc_wr), .hc_rd_in(hc_rd), .hc_addr_in(hc_addr),
    .hc_wdata_in(hc_wdata), .hc_rdata_out(hc_rdata), .hc_deposit_in(dep),
    .hc_deposit_buf_in(dep_buf), .hc_deposit_len_in(dep_len), .hc_done_in(hc_done),
    .all_eot_out(all_eot), .buf_status_out(status));
  function automatic logic [15:0] iso_word(input logic [7:0] ev, input logic [7:0] od);
    return {ev, od};
  endfunction
  function automatic logic [15:0] ack_word(input logic [7:0] ev, input logic [7:0] od);
    return {od, ev};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hcw(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_in);
    hc_wr    = 1'b1;
    hc_addr  = a;
    hc_wdata = d;
    @(negedge clk_in);
    hc_wr = 1'b0;
  endtask
  task automatic hcr(input logic [11:0] a);
    @(negedge clk_in);
    hc_rd   = 1'b1;
    hc_addr = a;
    @(negedge clk_in);
    hc_rd = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] code, input logic [15:0] exp);
    i_cpu.cmd(code);
    i_cpu.rd_n(0, 1);
    chk(i_cpu.rbuf[0], exp);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    stop_test;
  end
  initial begin
    hc_wr    = 1'b0;
    hc_rd    = 1'b0;
    dep      = 1'b0;
    dep_buf  = 1'b0;
    hc_addr  = 12'h000;
    hc_wdata = 8'h00;
    dep_len  = 16'h0000;
    hc_done  = 3'h0;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    rreg(8'h2D, 16'h0000);
    rreg(8'h2E, 16'h0000);
    chk({10'h000, status}, 16'h0000);
    i_cpu.wreg(8'hAA, ISO_LEN);
    i_cpu.wreg(8'hAB, ACK_LEN);
    for (int b = 0; b < 2; b++) begin
      @(negedge clk_in);
      dep     = 1'b1;
      dep_buf = b[0];
      dep_len = b ? {8'h00, 8'($random(seed))} : 16'h0008;
      @(negedge clk_in);
      dep = 1'b0;
      rreg(8'(8'h2D + b), dep_len);
    end
    chk({10'h000, status}, 16'h0003);
    $display("test readback lengths done");
    for (int i = 0; i < 8; i++) begin
      mem[i] = 8'($random(seed));
      hcw(12'(i), mem[i]);
    end
    i_cpu.wreg(8'hA2, 16'h0008);
    i_cpu.cmd(8'h40);
    i_cpu.rd_n(0, 3);
    repeat (2) @(negedge clk_in);
    chk({15'h0000, all_eot}, 16'h0000);
    i_cpu.rd_n(3, 1);
    @(negedge clk_in);
    chk({15'h0000, all_eot}, 16'h0001);
    chk({15'h0000, status[0]}, 16'h0000);
    for (int i = 0; i < 4; i++) chk(i_cpu.rbuf[i], iso_word(mem[2*i], mem[2*i+1]));
    rreg(8'h24, 16'h0004);
    rreg(8'h2C, 16'h0002);
    rreg(8'h22, 16'h0008);
    rreg(8'h2A, ISO_LEN);
    rreg(8'h2B, ACK_LEN);
    i_cpu.wreg(8'hA4, 16'h0004);
    chk({15'h0000, all_eot}, 16'h0000);
    $display("test iso read done");
    @(negedge clk_in);
    n = $random(seed) & 1;
    hc_done = {2'b11, n[0]};
    @(negedge clk_in);
    hc_done = 3'b000;
    @(negedge clk_in);
    chk({13'h0000, status[5:3]}, {13'h0000, 2'b11, n[0]});
    for (int i = 0; i < 2; i++) i_cpu.wbuf[i] = 16'($random(seed));
    i_cpu.wreg(8'hA2, 16'h0004);
    i_cpu.cmd(8'hC0);
    i_cpu.wr_n(2);
    @(negedge clk_in);
    chk({14'h0000, status[4], status[1]}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      hcr(ISO_LEN[11:0] + 12'(i));
      chk({8'h00, hc_rdata}, {8'h00, i[0] ? i_cpu.wbuf[i/2][7:0] : i_cpu.wbuf[i/2][15:8]});
    end
    i_cpu.wreg(8'hA4, 16'h0004);
    $display("test iso write done");
    for (int r = 0; r < 4; r++) begin
      n = 1 + ($random(seed) & 7);
      for (int i = 0; i < n; i++) i_cpu.wbuf[i] = 16'($random(seed));
      i_cpu.wreg(8'hA2, 16'(2 * n - (r == 3)));
      i_cpu.cmd(8'hC1);
      i_cpu.wr_n(n);
      @(negedge clk_in);
      chk({14'h0000, all_eot, status[2]}, 16'h0003);
      i_cpu.wreg(8'hA4, 16'h0004);
      hcr(12'(2 * ISO_LEN) + 12'(2 * n - 2));
      chk({8'h00, hc_rdata}, {8'h00, i_cpu.wbuf[n-1][7:0]});
      i_cpu.cmd(8'h41);
      i_cpu.rd_n(0, n);
      @(negedge clk_in);
      for (int i = 0; i < n; i++) begin
        chk(i_cpu.rbuf[i], ack_word(i_cpu.wbuf[i][7:0], i_cpu.wbuf[i][15:8]));
      end
      chk({14'h0000, all_eot, status[2]}, 16'h0002);
      i_cpu.wreg(8'hA4, 16'h0004);
    end
    $display("test acked port done");
    stop_test;
  end
endmodule // testbench
